// >>> src/pwm16_timer.sv
// apb-programmed sixteen-channel pulse-division pwm timer
`timescale 1ns/100ps
// Functional notes
// - one shared counter drives all sixteen channels
// - gate bit zero stops counter; reset value
// - gate one, choice zero: undivided clock
// - divider bits pick divide 2/4/8/16
// - pulse unit one tick; period 256 ticks
// - sixteen basic pulses per conversion period
// - select bit five always reads one
// - select bit four always reads zero
// - low nibble indexes duty register 0..15
// - sixteen readable writable eight-bit duty registers
// - reset clears all duty registers
// - upper nibble sets basic pulse width
// - lower nibble counts lengthened basic pulses
// - average ratio equals duty over 256
// - polarity bit inverts the channel waveform
// - direction and gate bits choose pin source
module pwm16_timer
    import pwm16_pkg::*;
#(
    parameter int CHANNELS = 16
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [CHANNELS-1:0] O_PIN_OUT,
    output logic [CHANNELS-1:0] O_PIN_OE_N
);
    // ==========================================================
    // register state
    logic [7:0] sel_reg;                        // clock_and_channel_select
    logic [7:0] duty [CHANNELS];                // channel_duty_values
    logic [CHANNELS-1:0] polarity;              // output_polarity_bits
    logic [CHANNELS-1:0] gates;                 // waveform_output_gates
    logic [CHANNELS-1:0] dir;                   // pin directions
    logic [CHANNELS-1:0] port_data;             // plain port output values
    logic [1:0] div_sel;                        // divider_select high/low
    logic [7:0] count;                          // shared_time_base_counter
    logic [3:0] prescale;                       // free divider of sys clock
    logic [CHANNELS-1:0] wave;                  // registered waveforms

    // ==========================================================
    // bus decode
    // setup phase alone never counts; the transfer lands with ready
    wire access = I_PSEL && I_PENABLE;
    wire done = access && O_PREADY;
    wire wr = done && I_PWRITE;
    // first access cycle: data captured, ready raised for the next
    wire first = access && !O_PREADY;
    wire hit_sel = I_PADDR == OFS_SELECT;
    wire hit_duty = I_PADDR == OFS_DUTY;
    wire hit_pol = I_PADDR == OFS_POLARITY;
    wire hit_gate = I_PADDR == OFS_GATES;
    wire hit_dir = I_PADDR == OFS_DIR;
    wire hit_pdat = I_PADDR == OFS_PORTDATA;
    wire hit_div = I_PADDR == OFS_CLKDIV;
    wire hit_cnt = I_PADDR == OFS_COUNT;
    wire mapped = hit_sel | hit_duty | hit_pol | hit_gate | hit_dir
        | hit_pdat | hit_div | hit_cnt;
    wire [3:0] duty_index = sel_reg[3:0];
    wire clk_gate = sel_reg[SEL_GATE_BIT];
    wire div_choice = sel_reg[SEL_DIVCHOICE_BIT];

    // zero-extend an eight or sixteen bit field to a bus word
    function automatic logic [31:0] word16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    // ==========================================================
    // read mux; unmapped reads return zero with slverr
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_sel) begin
            rd_mux = word16({8'h00, sel_reg});
        end else if (hit_duty) begin
            rd_mux = word16({8'h00, duty[duty_index]});
        end else if (hit_pol) begin
            rd_mux = word16(polarity);
        end else if (hit_gate) begin
            rd_mux = word16(gates);
        end else if (hit_dir) begin
            rd_mux = word16(dir);
        end else if (hit_pdat) begin
            rd_mux = word16(port_data);
        end else if (hit_div) begin
            rd_mux = word16({14'h0000, div_sel});
        end else if (hit_cnt) begin
            rd_mux = word16({8'h00, count});
        end
    end

    // error flagged only in the cycle the transfer completes
    assign O_PSLVERR = done && !mapped;

    // one wait state: ready rises the cycle after the first access
    // edge, so registered read data already stands when it is taken
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_PREADY <= 1'b0;
        end else begin
            O_PREADY <= first;
        end
    end

    // read data captured at the first access edge and held
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (first && !I_PWRITE) begin
            O_PRDATA <= rd_mux;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            sel_reg <= SEL_RESET;
            polarity <= '0;
            gates <= '0;
            dir <= '0;
            port_data <= '0;
            div_sel <= 2'b00;
        end else if (wr) begin
            if (hit_sel) begin
                sel_reg <= (I_PWDATA[7:0] & SEL_WRITE_MASK) | SEL_FIXED_ONES;
            end
            if (hit_pol) begin
                polarity <= I_PWDATA[CHANNELS-1:0];
            end
            if (hit_gate) begin
                gates <= I_PWDATA[CHANNELS-1:0];
            end
            if (hit_dir) begin
                dir <= I_PWDATA[CHANNELS-1:0];
            end
            if (hit_pdat) begin
                port_data <= I_PWDATA[CHANNELS-1:0];
            end
            if (hit_div) begin
                div_sel <= I_PWDATA[1:0];
            end
        end
    end

    // ==========================================================
    // duty register file
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            for (int i = 0; i < CHANNELS; i++) begin
                duty[i] <= DUTY_RESET;
            end
        end else if (wr && hit_duty) begin
            duty[duty_index] <= I_PWDATA[7:0];
        end
    end

    // ==========================================================
    // counter clock selection
    logic [3:0] div_mask;
    always_comb begin
        case (div_sel)
            2'b00: div_mask = DIV_MASK_2;
            2'b01: div_mask = DIV_MASK_4;
            2'b10: div_mask = DIV_MASK_8;
            default: div_mask = DIV_MASK_16;
        endcase
    end
    // tick when masked prescaler bits all one
    wire div_tick = (prescale & div_mask) == div_mask;
    // no tick while gated; every clock when undivided
    wire tick = clk_gate && (!div_choice || div_tick);

    // free-running prescaler
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            prescale <= 4'h0;
        end else begin
            prescale <= prescale + 4'h1;
        end
    end

    // count up on tick, natural wrap
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            count <= 8'h00;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

    // ==========================================================
    // pulse division
    // low nibble = position in basic pulse, high = pulse number
    wire [3:0] slot = count[3:0];
    wire [3:0] pulse_num = count[7:4];
    // bit-reversed pulse number spreads extras evenly
    wire [3:0] spread = {pulse_num[0], pulse_num[1], pulse_num[2],
        pulse_num[3]};

    // level of one channel at the current counter value
    function automatic logic chan_level(input logic [7:0] d);
        logic extra;
        extra = spread < d[3:0];
        // one extra unit on selected pulses
        // average high time equals d over 256
        return ({1'b0, slot} < ({1'b0, d[7:4]} + {4'h0, extra}));
    endfunction

    // output registered every clock, one clock behind the counter
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            wave <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                wave[i] <= chan_level(duty[i]) ^ polarity[i];
            end
        end
    end

    // ==========================================================
    // pin selection
    // dir 0 input, gate 0 port data, gate 1 waveform
    // full-on needs the port data path, or duty zero with the polarity bit set
    assign O_PIN_OUT = (gates & wave) | (~gates & port_data);
    assign O_PIN_OE_N = ~dir;

    // ==========================================================
    // assertions
    sel_fixed_bits_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            sel_reg[5] && !sel_reg[4])
        else $error("select fixed bits wrong");
    gated_hold_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            !clk_gate |=> count == $past(count))
        else $error("counter moved while gated");
    direct_tick_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (clk_gate && !div_choice) |=> count == $past(count) + 8'h01)
        else $error("undivided clock missed");
    div2_rate_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (clk_gate && div_choice && div_sel == 2'b00 && tick)
            |=> !tick)
        else $error("divide by two ticked twice");
    div16_gap_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (clk_gate && div_choice && div_sel == 2'b11 && tick)
            |=> !tick [*8])
        else $error("divide by sixteen too fast");
    wrap_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (tick && count == 8'hFF) |=> count == 8'h00)
        else $error("counter did not wrap");
    duty_write_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (wr && hit_duty) |=> duty[$past(duty_index)]
            == $past(I_PWDATA[7:0]))
        else $error("duty write lost");
    zero_duty_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            (duty[0] == 8'h00 && !polarity[0]) |=> !wave[0]
            || $past(duty[0]) != 8'h00 || $past(polarity[0]))
        else $error("zero duty produced pulse");
    ready_pulse_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            O_PREADY |=> !O_PREADY)
        else $error("ready held two cycles");
    pin_port_a:
        assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
            !gates[0] |-> O_PIN_OUT[0] == port_data[0])
        else $error("port data not on pin");
    cov_wrap_c: cover property (@(posedge I_SYS_CLK)
        tick && count == 8'hFF);
    cov_duty_c: cover property (@(posedge I_SYS_CLK) wr && hit_duty);
    cov_read_c: cover property (@(posedge I_SYS_CLK) done && !I_PWRITE);
    cov_div16_c: cover property (@(posedge I_SYS_CLK)
        tick && div_choice && div_sel == 2'b11);
endmodule

// >>> src/pwm16_pkg.sv
// shared constants for the sixteen-channel pulse-division pwm timer
package pwm16_pkg;
    // ==========================================================
    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_SELECT = 8'h00;  // clock_and_channel_select
    localparam logic [7:0] OFS_DUTY = 8'h04;    // window on selected duty reg
    localparam logic [7:0] OFS_POLARITY = 8'h08; // output_polarity_bits
    localparam logic [7:0] OFS_GATES = 8'h0C;   // waveform_output_gates
    localparam logic [7:0] OFS_DIR = 8'h10;     // pin direction bits
    localparam logic [7:0] OFS_PORTDATA = 8'h14; // plain port output data
    localparam logic [7:0] OFS_CLKDIV = 8'h18;  // divider_select high/low
    localparam logic [7:0] OFS_COUNT = 8'h1C;   // shared_time_base_counter
    // ==========================================================
    // select register field positions and fixed bits
    localparam int SEL_GATE_BIT = 7;            // counter_clock_gate
    localparam int SEL_DIVCHOICE_BIT = 6;       // divided_clock_choice
    localparam logic [7:0] SEL_FIXED_ONES = 8'h20; // bit 5 reads as one
    localparam logic [7:0] SEL_WRITE_MASK = 8'hCF; // bits 5 and 4 fixed
    localparam logic [7:0] SEL_RESET = 8'h20;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [3:0] DIV_MASK_2 = 4'h1;   // phase mask for each divide
    localparam logic [3:0] DIV_MASK_4 = 4'h3;
    localparam logic [3:0] DIV_MASK_8 = 4'h7;
    localparam logic [3:0] DIV_MASK_16 = 4'hF;
endpackage

// >>> testbench/pwm_load.sv
// external loads on the sixteen pwm pins, counting high time
`timescale 1ns/100ps
module pwm_load (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic [15:0] i_out,
    input wire logic [15:0] i_oe_n,
    output logic [15:0] o_level
);
    // ==========================================================
    // pin level
    // a released pin sits on its pull-down
    assign o_level = i_out & ~i_oe_n;
    // high-time counter of each pin
    int hi_cnt [16];
    // ==========================================================
    // counting
    // count cycles at high level, cleared on request
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < 16; c++) begin
            if (i_clr) begin
                hi_cnt[c] <= 0;
            end else if (o_level[c] === 1'b1) begin
                hi_cnt[c] <= hi_cnt[c] + 1;
            end
        end
    end
endmodule

// >>> testbench/pulse_division_pwm_16ch_tb.sv
// self-checking bench for the sixteen-channel pwm timer
`timescale 1ns/100ps
module pulse_division_pwm_16ch_tb;
    import pwm16_pkg::*;
    logic clk = 0;
    logic srst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, a;
    logic pready, pslverr, err;
    logic clr = 1;
    logic [15:0] pin_out, pin_oe_n, level;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t_done;
    pwm16_timer dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_PIN_OUT(pin_out), .O_PIN_OE_N(pin_oe_n));
    pwm_load load (.i_clk(clk), .i_clr(clr), .i_out(pin_out),
        .i_oe_n(pin_oe_n), .o_level(level));
    // ==========================================================
    // clock
    initial begin
        forever #5 clk = ~clk;
    end
    // free cycle count, read at the edge where ready is seen
    always @(posedge clk) cyc <= cyc + 1;
    // ==========================================================
    // shared tasks
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // compare and count
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
            fail_count++;
        end
    endtask
    // one apb transfer; waits for ready, then takes the answer
    task automatic apb(input logic wr, input logic [7:0] ad,
            input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            fail_count++;
            final_report();
        end
        // answer taken at the edge where ready was seen high
        err = pslverr;
        rd = prdata;
        t_done = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        apb(0, OFS_SELECT, 0);
        check("select", 32'h20, rd);
        apb(0, OFS_DUTY, 0);
        check("duty0", 32'h0, rd);
        check("oe_n", 32'hFFFF, {16'h0, pin_oe_n});
    endtask
    // fixed select bits ignore writes
    task automatic t_fixed;
        apb(1, OFS_SELECT, 32'h1F);
        apb(0, OFS_SELECT, 0);
        check("select", 32'h2F, rd);
        apb(1, 8'h40, 32'hFF);
        apb(0, 8'h40, 0);
        check("unmapped", 32'h0, rd);
        check("slverr", 32'h1, {31'h0, err});
    endtask
    // every duty register through the shared window
    task automatic t_duty;
        for (int c = 0; c < 16; c++) begin
            apb(1, OFS_SELECT, c);
            apb(1, OFS_DUTY, c * 17);
        end
        for (int c = 15; c >= 0; c--) begin
            apb(1, OFS_SELECT, c);
            apb(0, OFS_DUTY, 0);
            check("duty", c * 17, rd);
        end
    endtask
    // counter stops with gate off, counts every cycle undivided
    task automatic t_count;
        int t0;
        apb(1, OFS_COUNT, 32'h55);
        apb(0, OFS_COUNT, 0);
        check("count", 32'h0, rd);
        apb(1, OFS_SELECT, 32'h80);
        apb(0, OFS_COUNT, 0);
        a = rd;
        t0 = t_done;
        apb(0, OFS_COUNT, 0);
        // one count per clock between the two sampling edges
        check("step", (t_done - t0) & 32'hFF, (rd - a) & 32'hFF);
        apb(1, OFS_SELECT, 32'h00);
        apb(0, OFS_COUNT, 0);
        a = rd;
        apb(0, OFS_COUNT, 0);
        check("frozen", a, rd);
    endtask
    // high time of every pin over one conversion period
    task automatic t_wave(input logic [7:0] sel, input int code,
            input int div);
        int d, e;
        apb(1, OFS_CLKDIV, code);
        apb(1, OFS_SELECT, sel);
        repeat (300) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (256 * div) @(posedge clk);
        #1;
        for (int c = 0; c < 16; c++) begin
            d = c * 17;
            e = (c == 4) ? (256 - d) * div : d * div;
            // full-on pin uses plain port output, released pin reads 0
            if (c == 5) e = 256 * div;
            if (c == 6) e = 0;
            check("high_time", e, load.hi_cnt[c]);
        end
        check("oe_n", 32'h0040, {16'h0, pin_oe_n});
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_fixed();
        t_duty();
        t_count();
        apb(1, OFS_POLARITY, 32'h0010);
        apb(1, OFS_GATES, 32'hFFDF);
        apb(1, OFS_DIR, 32'hFFBF);
        apb(1, OFS_PORTDATA, 32'h0020);
        t_wave(8'h80, 0, 1);
        for (int m = 0; m < 4; m++) begin
            t_wave(8'hC0, m, 2 << m);
        end
        final_report();
    end
endmodule
